/* hdl/spdd_pkg.sv */
package spdd_pkg;
	// =========================================================
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
	localparam int DLY_MAX_MS    = 100;
	localparam int DLY_W         = 7;
	localparam int DIV_W         = 20;
	localparam logic [DIV_W-1:0] DIV_RST = 20'h01458; // 9600 bps
	localparam logic [DIV_W-1:0] DIV_MIN = 20'h00008;
	localparam int FRAME_W       = 12;
	localparam int FIFO_DEPTH    = 16;

	// =========================================================
	// register map
	localparam logic [11:0] OFF_CFG  = 12'h000;
	localparam logic [11:0] OFF_DIV  = 12'h004;
	localparam logic [11:0] OFF_DLY  = 12'h008;
	localparam logic [11:0] OFF_DATA = 12'h00c;
	localparam logic [11:0] OFF_STAT = 12'h010;
	localparam int CFG_PAR_LSB  = 0;
	localparam int CFG_STOP2    = 3;
	localparam int CFG_FLOW_LSB = 4;
	localparam int CFG_FIFO     = 6;
	localparam int CFG_IF_LSB   = 8;
	localparam logic [31:0] CFG_RST = 32'h00000040;
	localparam int DLY_ON_LSB   = 0;
	localparam int DLY_OFF_LSB  = 16;
	localparam int DATA_VALID   = 8;
	localparam int ST_TX_FULL   = 0;
	localparam int ST_TX_EMPTY  = 1;
	localparam int ST_RX_VALID  = 2;
	localparam int ST_RX_FULL   = 3;
	localparam int ST_RTS       = 4;
	localparam int ST_BUSY      = 5;
	localparam int ST_PERR      = 6;
	localparam int ST_FERR      = 7;
	localparam int ST_OVR       = 8;

	// =========================================================
	// modes and states
	typedef enum logic [2:0] {
		PAR_NONE  = 3'h0,
		PAR_ODD   = 3'h1,
		PAR_EVEN  = 3'h2,
		PAR_SPACE = 3'h3,
		PAR_MARK  = 3'h4
	} spdd_par_e;
	typedef enum logic [1:0] {
		FLOW_NONE   = 2'h0,
		FLOW_RTSCTS = 2'h1,
		FLOW_TOGGLE = 2'h2
	} spdd_flow_e;
	typedef enum logic [1:0] {
		IF_232    = 2'h0,
		IF_422    = 2'h1,
		IF_485_2W = 2'h2,
		IF_485_4W = 2'h3
	} spdd_if_e;
	typedef enum logic [1:0] {
		TX_IDLE  = 2'h0,
		TX_LEAD  = 2'h1,
		TX_SHIFT = 2'h2,
		TX_TAIL  = 2'h3
	} spdd_tx_e;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'h0,
		RX_START = 2'h1,
		RX_BITS  = 2'h2,
		RX_DONE  = 2'h3
	} spdd_rx_e;
endpackage

/* hdl/spdd_fifo.sv */
`timescale 1ns/10ps
module spdd_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         limit1,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("spdd_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   count_reg;
	logic          push;
	logic          pop;

	// capacity shrinks to one word when buffering is off
	assign in_ready  = limit1 ? (count_reg == '0) : (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // spdd_fifo

/* hdl/spdd_top.sv */
`timescale 1ns/10ps
module spdd_top #(
	parameter int CYC_PER_MS = spdd_pkg::CYC_PER_MS,
	parameter int FIFO_DEPTH = spdd_pkg::FIFO_DEPTH
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             txd,
	input  wire logic        rxd,
	output logic             rts_n,
	input  wire logic        cts_n,
	output logic [1:0]       iface_sel
);
	localparam int SUB_W = $clog2(CYC_PER_MS + 1);
	localparam int DW    = spdd_pkg::DIV_W;

	if (CYC_PER_MS < 2) begin : g_chk
		$error("spdd_top: CYC_PER_MS must be at least 2");
	end

	// =========================================================
	// settings
	logic [31:0]          cfg_reg;
	logic [DW-1:0]        div_reg;
	logic [6:0]           on_ms_reg;
	logic [6:0]           off_ms_reg;
	logic [2:0]           st_err_reg;
	spdd_pkg::spdd_par_e  par;
	spdd_pkg::spdd_flow_e flow;
	logic                 stop2;
	logic                 fifo_en;
	logic                 toggle;
	logic                 has_par;

	assign par       = spdd_pkg::spdd_par_e'(cfg_reg[spdd_pkg::CFG_PAR_LSB +: 3]);
	assign flow      = spdd_pkg::spdd_flow_e'(cfg_reg[spdd_pkg::CFG_FLOW_LSB +: 2]);
	assign stop2     = cfg_reg[spdd_pkg::CFG_STOP2];
	assign fifo_en   = cfg_reg[spdd_pkg::CFG_FIFO];
	assign iface_sel = cfg_reg[spdd_pkg::CFG_IF_LSB +: 2];
	assign has_par   = (par != spdd_pkg::PAR_NONE);
	// direction pulse only honoured on the RS-232 interface
	assign toggle    = (flow == spdd_pkg::FLOW_TOGGLE) && (iface_sel == spdd_pkg::IF_232);

	// parity bit for a character
	function automatic logic par_bit(input logic [7:0] d, input spdd_pkg::spdd_par_e p);
		case (p)
			spdd_pkg::PAR_ODD:  par_bit = ~^d;
			spdd_pkg::PAR_EVEN: par_bit = ^d;
			spdd_pkg::PAR_MARK: par_bit = 1'b1;
			default:            par_bit = 1'b0;
		endcase
	endfunction

	// =========================================================
	// ahb-lite slave, zero wait states
	logic        ap_take;
	logic        dp_wr_reg;
	logic [11:0] dp_addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_val;
	logic        wr_cfg;
	logic        wr_div;
	logic        wr_dly;
	logic        wr_data;
	logic        wr_stat;
	logic        rd_pop;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;
	assign ap_take   = hsel && htrans[1] && hready;
	assign wr_cfg    = dp_wr_reg && (dp_addr_reg == spdd_pkg::OFF_CFG);
	assign wr_div    = dp_wr_reg && (dp_addr_reg == spdd_pkg::OFF_DIV);
	assign wr_dly    = dp_wr_reg && (dp_addr_reg == spdd_pkg::OFF_DLY);
	assign wr_data   = dp_wr_reg && (dp_addr_reg == spdd_pkg::OFF_DATA);
	assign wr_stat   = dp_wr_reg && (dp_addr_reg == spdd_pkg::OFF_STAT);
	assign rd_pop    = ap_take && !hwrite && (haddr[11:0] == spdd_pkg::OFF_DATA);

	// fifo and engine wires
	logic       tx_in_ready;
	logic       tx_out_valid;
	logic       tx_out_ready;
	logic [7:0] tx_out_data;
	logic       rx_in_valid;
	logic       rx_in_ready;
	logic       rx_out_valid;
	logic [7:0] rx_out_data;
	logic [7:0] rx_char;
	spdd_pkg::spdd_tx_e tx_state_reg;

	// read mux, unmapped offsets read zero
	always_comb begin
		rd_val = 32'h00000000;
		case (haddr[11:0])
			spdd_pkg::OFF_CFG:  rd_val = cfg_reg;
			spdd_pkg::OFF_DIV:  rd_val = {{(32-DW){1'b0}}, div_reg};
			spdd_pkg::OFF_DLY:  rd_val = {9'h000, off_ms_reg, 9'h000, on_ms_reg};
			spdd_pkg::OFF_DATA: rd_val = {23'h000000, rx_out_valid, rx_out_data};
			spdd_pkg::OFF_STAT: rd_val = {23'h000000, st_err_reg, tx_state_reg != spdd_pkg::TX_IDLE,
				!rts_n, !rx_in_ready, rx_out_valid, !tx_out_valid, !tx_in_ready};
			default:            rd_val = 32'h00000000;
		endcase
	end

	// address phase capture and read data
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dp_wr_reg   <= 1'b0;
			dp_addr_reg <= 12'h000;
			hrdata_reg  <= 32'h00000000;
		end else begin
			dp_wr_reg <= ap_take && hwrite;
			if (ap_take) begin
				dp_addr_reg <= haddr[11:0];
			end
			if (ap_take && !hwrite) begin
				hrdata_reg <= rd_val;
			end
		end
	end

	// settings registers, one set per port instance
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg    <= spdd_pkg::CFG_RST;
			div_reg    <= spdd_pkg::DIV_RST;
			on_ms_reg  <= 7'h00;
			off_ms_reg <= 7'h00;
		end else begin
			if (wr_cfg) begin
				cfg_reg <= {22'h000000, hwdata[9:8], 1'b0, hwdata[6:0]};
			end
			if (wr_div) begin
				div_reg <= (hwdata[DW-1:0] < spdd_pkg::DIV_MIN) ? spdd_pkg::DIV_MIN
					: hwdata[DW-1:0];
			end
			if (wr_dly) begin
				on_ms_reg  <= (hwdata[6:0] > 7'(spdd_pkg::DLY_MAX_MS)) ? 7'(spdd_pkg::DLY_MAX_MS)
					: hwdata[6:0];
				off_ms_reg <= (hwdata[22:16] > 7'(spdd_pkg::DLY_MAX_MS))
					? 7'(spdd_pkg::DLY_MAX_MS) : hwdata[22:16];
			end
		end
	end

	// =========================================================
	// buffers
	spdd_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.limit1    (!fifo_en),
		.in_valid  (wr_data),
		.in_ready  (tx_in_ready),
		.in_data   (hwdata[7:0]),
		.out_valid (tx_out_valid),
		.out_ready (tx_out_ready),
		.out_data  (tx_out_data)
	);

	spdd_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.limit1    (!fifo_en),
		.in_valid  (rx_in_valid),
		.in_ready  (rx_in_ready),
		.in_data   (rx_char),
		.out_valid (rx_out_valid),
		.out_ready (rd_pop),
		.out_data  (rx_out_data)
	);

	// =========================================================
	// pin synchronisers
	logic rx_s1_reg;
	logic rx_s2_reg;
	logic cts_s1_reg;
	logic cts_s2_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_s1_reg  <= 1'b1;
			rx_s2_reg  <= 1'b1;
			cts_s1_reg <= 1'b1;
			cts_s2_reg <= 1'b1;
		end else begin
			rx_s1_reg  <= rxd;
			rx_s2_reg  <= rx_s1_reg;
			cts_s1_reg <= cts_n;
			cts_s2_reg <= cts_s1_reg;
		end
	end

	// =========================================================
	// transmitter
	logic [11:0]      tx_shift_reg;
	logic [3:0]       tx_bits_reg;
	logic [DW-1:0]    tx_cyc_reg;
	logic [6:0]       ms_left_reg;
	logic [SUB_W-1:0] ms_sub_reg;
	logic             can_start;
	logic             bit_end;
	logic             ms_tick;
	logic [11:0]      frame;
	logic [3:0]       nbits;

	// in RTS/CTS flow mode, hold new characters while the far end shows CTS off
	assign can_start    = tx_out_valid && ((flow != spdd_pkg::FLOW_RTSCTS) || !cts_s2_reg);
	assign bit_end      = (tx_cyc_reg == div_reg - 1'b1);
	assign ms_tick      = (ms_sub_reg == SUB_W'(CYC_PER_MS - 1));
	assign frame        = {2'b11, has_par ? par_bit(tx_out_data, par) : 1'b1, tx_out_data, 1'b0};
	assign nbits        = 4'ha + {3'h0, has_par} + {3'h0, stop2};
	assign txd          = tx_shift_reg[0];
	assign tx_out_ready = (can_start && (tx_state_reg == spdd_pkg::TX_IDLE) && !toggle)
		|| ((tx_state_reg == spdd_pkg::TX_LEAD) && (ms_left_reg == 7'h00))
		|| ((tx_state_reg == spdd_pkg::TX_SHIFT) && bit_end && (tx_bits_reg == 4'h1) && can_start);

	// rts level per flow mode
	always_comb begin
		if (toggle) begin
			rts_n = (tx_state_reg == spdd_pkg::TX_IDLE);
		end else if (flow == spdd_pkg::FLOW_RTSCTS) begin
			rts_n = !rx_in_ready;
		end else begin
			rts_n = 1'b0;
		end
	end

	// frame sequencer with lead and tail waits
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg <= spdd_pkg::TX_IDLE;
			tx_shift_reg <= 12'hfff;
			tx_bits_reg  <= 4'h0;
			tx_cyc_reg   <= '0;
			ms_left_reg  <= 7'h00;
			ms_sub_reg   <= '0;
		end else begin
			case (tx_state_reg)
				spdd_pkg::TX_IDLE: begin
					ms_sub_reg <= '0;
					if (toggle && tx_out_valid) begin
						ms_left_reg  <= on_ms_reg;
						tx_state_reg <= spdd_pkg::TX_LEAD;
					end else if (tx_out_ready) begin
						tx_shift_reg <= frame;
						tx_bits_reg  <= nbits;
						tx_cyc_reg   <= '0;
						tx_state_reg <= spdd_pkg::TX_SHIFT;
					end
				end
				spdd_pkg::TX_LEAD: begin
					if (ms_left_reg == 7'h00) begin
						tx_shift_reg <= frame;
						tx_bits_reg  <= nbits;
						tx_cyc_reg   <= '0;
						tx_state_reg <= spdd_pkg::TX_SHIFT;
					end else if (ms_tick) begin
						ms_sub_reg  <= '0;
						ms_left_reg <= ms_left_reg - 1'b1;
					end else begin
						ms_sub_reg <= ms_sub_reg + 1'b1;
					end
				end
				spdd_pkg::TX_SHIFT: begin
					if (!bit_end) begin
						tx_cyc_reg <= tx_cyc_reg + 1'b1;
					end else if (tx_bits_reg != 4'h1) begin
						tx_cyc_reg   <= '0;
						tx_bits_reg  <= tx_bits_reg - 1'b1;
						tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
					end else if (can_start) begin
						tx_shift_reg <= frame;
						tx_bits_reg  <= nbits;
						tx_cyc_reg   <= '0;
					end else begin
						tx_shift_reg <= 12'hfff;
						ms_sub_reg   <= '0;
						ms_left_reg  <= off_ms_reg;
						tx_state_reg <= toggle ? spdd_pkg::TX_TAIL : spdd_pkg::TX_IDLE;
					end
				end
				spdd_pkg::TX_TAIL: begin
					if (ms_left_reg == 7'h00) begin
						tx_state_reg <= spdd_pkg::TX_IDLE;
					end else if (ms_tick) begin
						ms_sub_reg  <= '0;
						ms_left_reg <= ms_left_reg - 1'b1;
					end else begin
						ms_sub_reg <= ms_sub_reg + 1'b1;
					end
				end
				default: tx_state_reg <= spdd_pkg::TX_IDLE;
			endcase
		end
	end

	// =========================================================
	// receiver
	spdd_pkg::spdd_rx_e rx_state_reg;
	logic [10:0]        rx_shift_reg;
	logic [3:0]         rx_idx_reg;
	logic [DW-1:0]      rx_cyc_reg;
	logic [3:0]         rx_total;
	logic [3:0]         stop_pos;
	logic               perr;
	logic               ferr;

	assign rx_total    = 4'h9 + {3'h0, has_par} + {3'h0, stop2};
	assign stop_pos    = 4'h8 + {3'h0, has_par};
	assign rx_char     = rx_shift_reg[7:0];
	assign rx_in_valid = (rx_state_reg == spdd_pkg::RX_DONE);
	assign perr        = has_par && (rx_shift_reg[8] != par_bit(rx_char, par));
	assign ferr        = !rx_shift_reg[stop_pos] || (stop2 && !rx_shift_reg[stop_pos + 4'h1]);

	// mid-bit sampler
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_reg <= spdd_pkg::RX_IDLE;
			rx_shift_reg <= 11'h000;
			rx_idx_reg   <= 4'h0;
			rx_cyc_reg   <= '0;
		end else begin
			case (rx_state_reg)
				spdd_pkg::RX_IDLE: begin
					rx_cyc_reg <= '0;
					if (!rx_s2_reg) begin
						rx_state_reg <= spdd_pkg::RX_START;
					end
				end
				spdd_pkg::RX_START: begin
					if (rx_cyc_reg != (div_reg >> 1)) begin
						rx_cyc_reg <= rx_cyc_reg + 1'b1;
					end else begin
						rx_cyc_reg   <= '0;
						rx_idx_reg   <= 4'h0;
						rx_state_reg <= rx_s2_reg ? spdd_pkg::RX_IDLE : spdd_pkg::RX_BITS;
					end
				end
				spdd_pkg::RX_BITS: begin
					if (rx_cyc_reg != div_reg - 1'b1) begin
						rx_cyc_reg <= rx_cyc_reg + 1'b1;
					end else begin
						rx_cyc_reg               <= '0;
						rx_shift_reg[rx_idx_reg] <= rx_s2_reg;
						rx_idx_reg               <= rx_idx_reg + 1'b1;
						if (rx_idx_reg == rx_total - 4'h1) begin
							rx_state_reg <= spdd_pkg::RX_DONE;
						end
					end
				end
				spdd_pkg::RX_DONE: rx_state_reg <= spdd_pkg::RX_IDLE;
				default:           rx_state_reg <= spdd_pkg::RX_IDLE;
			endcase
		end
	end

	// sticky errors, write one clears, a new event wins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_err_reg <= 3'h0;
		end else begin
			st_err_reg <= (st_err_reg & ~(wr_stat ? hwdata[8:6] : 3'h0))
				| (rx_in_valid ? {!rx_in_ready, ferr, perr} : 3'h0);
		end
	end
endmodule // spdd_top

/* tb/spdd_sva.sv */
`timescale 1ns/10ps
// =========================================================
// port checker
module spdd_sva #(
	parameter int CYC_PER_MS = spdd_pkg::CYC_PER_MS
) (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        txd,
	input wire logic        rts_n,
	input wire logic [1:0]  iface_sel
);
	logic        ph_w;
	logic        started;
	logic [11:0] ph_a;
	logic [31:0] cfg_q;
	logic [31:0] dly_q;
	int          since;
	int          hi_cnt;
	wire         tog = cfg_q[5:4] == 2'h2 && cfg_q[9:8] == 2'h0;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// shadow copy of settings written over the bus
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ph_w  <= 1'b0;
			ph_a  <= 12'h000;
			cfg_q <= spdd_pkg::CFG_RST;
			dly_q <= 32'h00000000;
		end else begin
			ph_w <= hsel && htrans[1] && hready && hwrite;
			ph_a <= haddr[11:0];
			if (ph_w && ph_a == spdd_pkg::OFF_CFG) cfg_q <= hwdata;
			if (ph_w && ph_a == spdd_pkg::OFF_DLY) dly_q <= hwdata;
		end
	end

	// cycles since rts asserted, and since txd was last low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			since   <= 0;
			started <= 1'b0;
			hi_cnt  <= 0;
		end else begin
			since   <= rts_n ? 0 : since + 1;
			started <= rts_n ? 1'b0 : (started || !txd);
			hi_cnt  <= txd ? hi_cnt + 1 : 0;
		end
	end

	property p_okay; hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus answer not okay");
	property p_iface; iface_sel == cfg_q[9:8]; endproperty
	a_iface: assert property (p_iface) else $error("interface select wrong");
	property p_hrd; !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata); endproperty
	a_hrd: assert property (p_hrd) else $error("read data moved");
	property p_none; cfg_q[5:4] == 2'h0 |-> !rts_n; endproperty
	a_none: assert property (p_none) else $error("rts off in no-flow mode");
	property p_other; cfg_q[5:4] == 2'h2 && cfg_q[9:8] != 2'h0 |-> !rts_n; endproperty
	a_other: assert property (p_other) else $error("pulse mode off rs232");
	property p_rtstx; tog && !txd |-> !rts_n; endproperty
	a_rtstx: assert property (p_rtstx) else $error("data sent with rts off");
	property p_lead;
		tog && $fell(txd) && !started |-> since == dly_q[6:0] * CYC_PER_MS + 1;
	endproperty
	a_lead: assert property (p_lead) else $error("lead delay wrong");
	property p_tail; tog && $rose(rts_n) |-> hi_cnt > dly_q[22:16] * CYC_PER_MS; endproperty
	a_tail: assert property (p_tail) else $error("tail delay too short");
endmodule // spdd_sva

bind spdd_top spdd_sva #(.CYC_PER_MS(CYC_PER_MS)) i_sva (
	.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .txd(txd), .rts_n(rts_n), .iface_sel(iface_sel)
);

/* tb/spdd_far.sv */
`timescale 1ns/10ps
// =========================================================
// serial field device model
module spdd_far (
	input  wire logic clock,
	input  wire logic txd,
	input  wire logic rts_n,
	output logic      rxd,
	output logic      cts_n
);
	int         div = 8;
	int         par = 0;
	int         stop2 = 0;
	logic [9:0] f;
	logic [9:0] got[$];

	// idle line is mark, handshake open
	initial begin
		rxd   = 1'b1;
		cts_n = 1'b0;
	end

	// decode frames by mid-bit sampling; keeps {stops ok, parity, data}
	always begin
		@(negedge txd);
		repeat (div / 2) @(posedge clock);
		f = 10'h200;
		for (int i = 0; i < 9 + (par != 0) + stop2; i++) begin
			repeat (div) @(posedge clock);
			if (i < 8) f[i] = txd;
			else if (i == 8 && par != 0) f[8] = txd;
			else f[9] = f[9] & txd;
		end
		got.push_back(f);
	end

	// send one char, only while the port accepts
	task automatic send(input logic [7:0] c, input logic p);
		logic [11:0] b;
		b = (par != 0) ? {2'b11, p, c, 1'b0} : {3'b111, c, 1'b0};
		while (rts_n) @(posedge clock);
		for (int i = 0; i < 10 + (par != 0) + stop2; i++) begin
			@(posedge clock);
			rxd <= b[i];
			repeat (div - 1) @(posedge clock);
		end
		@(posedge clock);
		rxd <= 1'b1;
	endtask
endmodule // spdd_far

/* tb/tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("Error at %0t: got %0h expected %0h", $time, g, e); end end
// =========================================================
// bench top
module tb;
	logic        clock;
	logic        rst_n;
	logic        hsel;
	logic        hwrite;
	logic        hreadyout;
	logic        hresp;
	logic        txd;
	logic        rxd;
	logic        rts_n;
	logic        cts_n;
	logic [1:0]  htrans;
	logic [1:0]  iface_sel;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] r;
	logic [31:0] v;
	logic [31:0] seed = 32'h0000001e;
	logic [9:0]  exq[$];
	int          n_errors;
	int          n_compared;
	int          cyc;
	int          n;
	int          lead;
	int          tail;

	spdd_top #(.CYC_PER_MS(10), .FIFO_DEPTH(4)) i_dut (
		.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txd(txd), .rxd(rxd),
		.rts_n(rts_n), .cts_n(cts_n), .iface_sel(iface_sel));
	spdd_far i_far (.clock(clock), .txd(txd), .rts_n(rts_n), .rxd(rxd), .cts_n(cts_n));

	// clock and hang guard
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic pbit(input logic [7:0] c);
		case (i_far.par)
			1: return ~^c;
			2: return ^c;
			4: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// one single bus transfer; read data lands in r
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel   <= 1'b1;
		haddr  <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clock);
		while (!hreadyout) @(posedge clock);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (!hreadyout) @(posedge clock);
		r = hrdata;
	endtask
	task automatic put(input logic [7:0] c);
		bus(1'b1, spdd_pkg::OFF_DATA, {24'h000000, c});
		exq.push_back({1'b1, pbit(c), c});
	endtask
	task automatic tx_chk();
		logic [9:0] g;
		logic [9:0] e;
		while (i_far.got.size() == 0) @(posedge clock);
		g = i_far.got.pop_front();
		e = exq.pop_front();
		`CHK(g, e)
	endtask
	task report_and_stop();
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		rst_n  = 1'b0;
		hsel   = 1'b0;
		haddr  = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		bus(1'b0, spdd_pkg::OFF_CFG, 32'h0);
		`CHK(r, spdd_pkg::CFG_RST)
		bus(1'b0, spdd_pkg::OFF_DIV, 32'h0);
		`CHK(r, {12'h000, spdd_pkg::DIV_RST})
		bus(1'b0, spdd_pkg::OFF_DLY, 32'h0);
		`CHK(r, 32'h00000000)
		bus(1'b1, spdd_pkg::OFF_DIV, 32'h00000001);
		bus(1'b0, spdd_pkg::OFF_DIV, 32'h0);
		`CHK(r, {12'h000, spdd_pkg::DIV_MIN})
		bus(1'b1, spdd_pkg::OFF_DLY, 32'h00ff00ff);
		bus(1'b0, spdd_pkg::OFF_DLY, 32'h0);
		`CHK(r, 32'h00640064)
		bus(1'b1, 12'h014, 32'hffffffff);
		bus(1'b0, 12'h014, 32'h0);
		`CHK(r, 32'h00000000)
		for (int p = 0; p < 5; p++) begin
			i_far.par   = p;
			i_far.stop2 = int'(rnd() % 2);
			i_far.div   = 8 + int'(rnd() % 16);
			bus(1'b1, spdd_pkg::OFF_DIV, 32'(i_far.div));
			bus(1'b1, spdd_pkg::OFF_CFG, 32'(p + i_far.stop2 * 8 + 64));
			v = rnd();
			put(v[7:0]);
			tx_chk();
			v = rnd();
			i_far.send(v[7:0], pbit(v[7:0]));
			repeat (4) @(posedge clock);
			bus(1'b0, spdd_pkg::OFF_DATA, 32'h0);
			`CHK(r, {23'h000000, 1'b1, v[7:0]})
		end
		i_far.par   = 0;
		i_far.stop2 = 0;
		i_far.div   = 8;
		bus(1'b1, spdd_pkg::OFF_DIV, 32'h00000008);
		for (int k = 0; k < 2; k++) begin
			lead = 1 - k;
			tail = 2 - 2 * k;
			bus(1'b1, spdd_pkg::OFF_DLY, 32'(lead + tail * 65536));
			bus(1'b1, spdd_pkg::OFF_CFG, 32'h00000060);
			fork
				begin
					v = rnd();
					put(v[7:0]);
					v = rnd();
					put(v[7:0]);
				end
				begin
					@(negedge rts_n);
					n = 0;
					while (txd) begin
						@(posedge clock);
						#1;
						n++;
					end
					`CHK(n, lead * 10 + 1)
					n = 0;
					while (!rts_n) begin
						@(posedge clock);
						#1;
						n++;
					end
					`CHK(n, 2 * 10 * 8 + tail * 10 + 1)
				end
			join
			tx_chk();
			tx_chk();
		end
		for (int f = 1; f < 4; f++) begin
			bus(1'b1, spdd_pkg::OFF_CFG, 32'(96 + f * 256));
			v = rnd();
			put(v[7:0]);
			repeat (3) @(posedge clock);
			#1;
			`CHK(rts_n, 1'b0)
			`CHK(iface_sel, 2'(f))
			tx_chk();
		end
		bus(1'b1, spdd_pkg::OFF_CFG, 32'h00000010);
		i_far.cts_n <= 1'b1;
		v = rnd();
		put(v[7:0]);
		repeat (40) @(posedge clock);
		`CHK(i_far.got.size(), 0)
		i_far.cts_n <= 1'b0;
		tx_chk();
		v = rnd();
		i_far.send(v[7:0], 1'b0);
		repeat (4) @(posedge clock);
		#1;
		`CHK(rts_n, 1'b1)
		bus(1'b0, spdd_pkg::OFF_STAT, 32'h0);
		`CHK(r, 32'h0000000e)
		bus(1'b0, spdd_pkg::OFF_DATA, 32'h0);
		`CHK(r, {23'h000000, 1'b1, v[7:0]})
		@(negedge clock);
		`CHK(rts_n, 1'b0)
		report_and_stop();
	end
endmodule // tb
